// ==== rtl/wcg_divider.sv ====
// Purpose: programmable output divider with a doubled-rate output
// Assumes: src_tick_in marks one half-period of the source clock
// Notes:   doubled output is held low for the odd divisors one and three

`timescale 1ns/100ps

module wcg_divider (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // source and divisor
  input wire logic src_tick_in,
  input wire logic [2:0] div_code_in,
  // divided clocks
  output logic clk_out,
  output logic clk_double_out,
  output logic bit_tick_out
);

  logic [4:0] divisor;
  logic [4:0] cnt_r;
  logic dbl_avail;
  logic at_end;
  logic at_half;

  assign divisor = wcg_pkg::wcg_div_value(div_code_in);
  assign dbl_avail = div_code_in != wcg_pkg::DIV_ONE
    && div_code_in != wcg_pkg::DIV_THREE;
  assign at_end = cnt_r >= divisor - 5'h01;
  assign at_half = cnt_r == (divisor >> 1) - 5'h01;

  // ==========================================================
  // counter wraps at or above divisor minus one, so a smaller new divisor
  // cannot strand it
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_r <= '0;
    end else if (src_tick_in) begin
      cnt_r <= at_end ? 5'h00 : cnt_r + 5'h01;
    end
  end

  // main output toggles every divisor source half-periods
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      clk_out <= 1'b0;
      bit_tick_out <= 1'b0;
    end else begin
      bit_tick_out <= src_tick_in && at_end && !clk_out;
      if (src_tick_in && at_end) begin
        clk_out <= ~clk_out;
      end
    end
  end

  // doubled output toggles at the half and at the end of each count
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !dbl_avail) begin
      clk_double_out <= 1'b0;
    end else if (src_tick_in && (at_end || at_half)) begin
      clk_double_out <= ~clk_double_out;
    end
  end

  a_div_one_toggle: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in)
    (src_tick_in && div_code_in == 3'h0) |=> clk_out != $past(clk_out))
    else $error("divide by one did not toggle");

  a_double_held: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in)
    !dbl_avail |=> !clk_double_out)
    else $error("doubled clock ran on odd divisor");

endmodule

// ==== rtl/wcg_dpll.sv ====
// Purpose: digital loop that multiplies the reference into a tick stream
// Assumes: reference arrives as one-cycle ticks on the system clock
// Notes:   nco rate adjusts once per reference tick

`timescale 1ns/100ps

module wcg_dpll #(
  parameter int STEP_W = 24,
  parameter int ADJ_SHIFT = 8,
  parameter logic [23:0] STEP_INIT = 24'h100000
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // loop inputs
  input wire logic ref_tick_in,
  input wire logic [10:0] mult_q_in,
  input wire logic [2:0] bw_shift_in,
  input wire logic signed [6:0] pos_err_in,
  // output tick
  output logic pll_tick_out
);

  logic [STEP_W-1:0] acc_r;
  logic [STEP_W-1:0] step_r;
  logic [STEP_W:0] acc_sum;
  logic [11:0] count_q_r;
  logic signed [13:0] corr;
  logic signed [STEP_W-1:0] adj;

  // ==========================================================
  // nco: carry out of the accumulator is the output tick
  assign acc_sum = {1'b0, acc_r} + {1'b0, step_r};

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      acc_r <= '0;
      pll_tick_out <= 1'b0;
    end else begin
      acc_r <= acc_sum[STEP_W-1:0];
      pll_tick_out <= acc_sum[STEP_W];
    end
  end

  // count output ticks per reference period, in quarter units
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      count_q_r <= '0;
    end else if (ref_tick_in) begin
      count_q_r <= '0;
    end else if (pll_tick_out && count_q_r < 12'hFF0) begin
      count_q_r <= count_q_r + 12'h004;
    end
  end

  // frequency error minus position error drives the step toward lock
  assign corr = $signed({3'h0, mult_q_in}) - $signed({2'h0, count_q_r})
    - 14'(pos_err_in);
  assign adj = (STEP_W'(corr) <<< ADJ_SHIFT) >>> bw_shift_in;

  // reserved multiplier leaves the rate where it is
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      step_r <= STEP_INIT;
    end else if (ref_tick_in && mult_q_in != 11'h000) begin
      step_r <= step_r + adj;
    end
  end

endmodule

// ==== rtl/wcg_pkg.sv ====
// Purpose: shared constants, field layout and config carrier for the
//          write clock output control block
// Assumes: registers are 8 bits wide and sit in the low byte of a word
// Notes:   printed offsets are register indices; byte address = 4 * index

package wcg_pkg;

  // ==========================================================
  // register indices
  localparam logic [7:0] IDX_CLK_CTRL_A = 8'h34;
  localparam logic [7:0] IDX_CLK_CTRL_B = 8'h35;
  localparam logic [7:0] IDX_MOD_CTRL_A = 8'h3D;
  localparam logic [7:0] IDX_MOD_CTRL_B = 8'h3E;
  localparam logic [7:0] IDX_STATUS = 8'h3F;

  // ==========================================================
  // field positions
  localparam int BW_LSB = 5;
  localparam int BYPASS_BIT = 4;
  localparam int DIV_LSB = 1;
  localparam int REF_LSB = 6;
  localparam int POS_LSB = 4;
  localparam int MULT_LSB = 0;
  localparam int LWRT_EN_BIT = 5;
  localparam int LWRT_ON_BIT = 4;
  localparam int GATE_BIT = 3;
  localparam int PAT_LO_LSB = 1;
  localparam int OVR_BIT = 2;
  localparam int FORCED_BIT = 1;
  localparam int PAT_HI_BIT = 0;

  // ==========================================================
  // encodings
  localparam logic [1:0] REF_WOBBLE = 2'h0;
  localparam logic [1:0] REF_WORD = 2'h1;
  localparam logic [1:0] REF_SYSDIV = 2'h2;
  localparam logic [1:0] POS_NONE = 2'h0;
  localparam logic [1:0] POS_PHASE = 2'h2;
  localparam logic [1:0] POS_FILL = 2'h3;
  localparam logic [2:0] PAT_ZERO = 3'h0;
  localparam logic [2:0] PAT_NORMAL = 3'h1;
  localparam logic [2:0] PAT_SHORT = 3'h2;
  localparam logic [2:0] PAT_LONG = 3'h3;
  localparam logic [2:0] PAT_OPC = 3'h5;
  localparam logic [2:0] DIV_ONE = 3'h0;
  localparam logic [2:0] DIV_THREE = 3'h2;

  // ==========================================================
  // run lengths and timing
  localparam logic [3:0] SHORT_RUN = 4'h3;
  localparam logic [3:0] LONG_RUN = 4'hB;
  localparam logic [3:0] OPC_BASE_RUN = 4'h3;
  localparam logic [3:0] OPC_LAST_IDX = 4'h9;
  localparam logic [7:0] SYSDIV_LAST = 8'hBF;  // 192 system clocks
  localparam int CLK_PERIOD_NS = 20;

  // ==========================================================
  // configuration carrier
  typedef struct packed {
    logic [2:0] bw;
    logic bypass;
    logic [2:0] div;
    logic [1:0] ref_src;
    logic [1:0] pos_src;
    logic [3:0] mult;
    logic lwrt_en;
    logic lwrt_on;
    logic gate_force;
    logic [2:0] pat_sel;
    logic override;
    logic forced_on;
  } wcg_cfg_t;

  localparam wcg_cfg_t CFG_RESET = '0;

  // divisor per code
  function automatic logic [4:0] wcg_div_value(input logic [2:0] code);
    case (code)
      3'h0: wcg_div_value = 5'h01;
      3'h1: wcg_div_value = 5'h02;
      3'h2: wcg_div_value = 5'h03;
      3'h3: wcg_div_value = 5'h04;
      3'h4: wcg_div_value = 5'h06;
      3'h5: wcg_div_value = 5'h08;
      3'h6: wcg_div_value = 5'h0C;
      default: wcg_div_value = 5'h10;
    endcase
  endfunction

  // multiplication factor in quarter units; zero for reserved codes
  function automatic logic [10:0] wcg_mult_q(input logic [3:0] code);
    case (code)
      4'h0: wcg_mult_q = 11'h498;  // 294
      4'h1: wcg_mult_q = 11'h310;  // 196
      4'h2: wcg_mult_q = 11'h24C;  // 147
      4'h4: wcg_mult_q = 11'h188;  // 98
      4'h6: wcg_mult_q = 11'h126;  // 73.5
      4'h8: wcg_mult_q = 11'h0C4;  // 49
      4'hA: wcg_mult_q = 11'h093;  // 36.75
      default: wcg_mult_q = 11'h000;
    endcase
  endfunction

  // bandwidth halves per step: 400, 200, 100, 50, 25 Hz
  function automatic logic [2:0] wcg_bw_shift(input logic [2:0] code);
    wcg_bw_shift = (code > 3'h4) ? 3'h4 : code;
  endfunction

endpackage

// ==== rtl/wcg_write_clock_ctrl.sv ====
// Purpose: write clock reference select, divider, gating and pattern out
// Assumes: apb slave, zero wait states, byte address = 4 * index
// Notes:   reference pins are synchronised; other inputs share the clock
//
// Overview of operation
// - override clear: write clock follows the clock gate force bit or the data flow flag.
// - override set: write clock off if forced-on is 0, running if 1.
// - pattern 000 zero, 001 modulated data, 010 short run, 011 long run.
// - pattern 101 emits runs 3-3-4-4-5-5-6-6-7-7 repeating.
// - pattern select top bit is bit 0 of modulator control b.
// - reference chosen from three sources by a multiplexer.
// - digital loop multiplies reference and steers away position error.
// - loop output can be replaced by another source, bypassing it.
// - bypass bit 4 set derives the write clock from the system clock.
// - bits 7..5 set loop bandwidth 400 down to 25 Hz.
// - bits 3..1 set divisor 1,2,3,4,6,8,12,16.
// - doubled write clock exists except for divisors one and three.
// - reference codes: wobble, word clock, system clock over 192.
// - control b holds position source in 5..4, multiplier in 3..0.
// - position source 00 none, 10 phase error, 11 fill level.
// - multiplier codes give 294,196,147,98,73.5,49,36.75.
// - gate force 0 runs clock only with data flow; 1 always.
// - pattern select low bits sit in bits 2 and 1 of control a.

`timescale 1ns/100ps

module wcg_write_clock_ctrl #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reference pins
  input wire logic wobble_carrier_pulse_in,
  input wire logic word_clock_in,
  // encoder side, same clock
  input wire logic data_flow_flag_in,
  input wire logic write_active_flag_in,
  input wire logic modulated_data_in,
  input wire logic [6:0] phase_position_error_in,
  input wire logic [6:0] buffer_fill_level_in,
  // write channel
  output logic write_clock_out,
  output logic write_clock_double_out,
  output logic write_data_out,
  output logic laser_enable_out
);

  wcg_pkg::wcg_cfg_t cfg_r;
  logic [ADDR_W-3:0] reg_idx;
  logic idx_ok;
  logic wr_en;
  logic [7:0] rd_nxt;
  logic [1:0] pin_sync1_r;
  logic [1:0] pin_sync2_r;
  logic [1:0] pin_prev_r;
  logic [1:0] pin_tick;
  logic [7:0] sysdiv_cnt_r;
  logic sysdiv_tick;
  logic ref_tick;
  logic signed [6:0] pos_err;
  logic pll_tick;
  logic src_tick;
  logic div_clk;
  logic div_dbl;
  logic bit_tick;
  logic clock_run;
  logic [3:0] run_cnt_r;
  logic [3:0] opc_idx_r;
  logic [3:0] run_len;
  logic pat_level_r;
  logic data_nxt;

  // ==========================================================
  // apb decode: zero wait, word aligned, unmapped answers with error
  assign reg_idx = paddr[ADDR_W-1:2];
  assign idx_ok = paddr[1:0] == 2'h0 && (
    reg_idx == (ADDR_W-2)'(wcg_pkg::IDX_CLK_CTRL_A) ||
    reg_idx == (ADDR_W-2)'(wcg_pkg::IDX_CLK_CTRL_B) ||
    reg_idx == (ADDR_W-2)'(wcg_pkg::IDX_MOD_CTRL_A) ||
    reg_idx == (ADDR_W-2)'(wcg_pkg::IDX_MOD_CTRL_B) ||
    reg_idx == (ADDR_W-2)'(wcg_pkg::IDX_STATUS));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !idx_ok;
  assign wr_en = psel && penable && pwrite && idx_ok;

  // only defined fields are stored; reserved bits fall away
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cfg_r <= wcg_pkg::CFG_RESET;
    end else if (wr_en) begin
      case (reg_idx[7:0])
        wcg_pkg::IDX_CLK_CTRL_A: begin
          cfg_r.bw <= pwdata[wcg_pkg::BW_LSB +: 3];
          cfg_r.bypass <= pwdata[wcg_pkg::BYPASS_BIT];
          cfg_r.div <= pwdata[wcg_pkg::DIV_LSB +: 3];
        end
        wcg_pkg::IDX_CLK_CTRL_B: begin
          cfg_r.ref_src <= pwdata[wcg_pkg::REF_LSB +: 2];
          cfg_r.pos_src <= pwdata[wcg_pkg::POS_LSB +: 2];
          cfg_r.mult <= pwdata[wcg_pkg::MULT_LSB +: 4];
        end
        wcg_pkg::IDX_MOD_CTRL_A: begin
          cfg_r.lwrt_en <= pwdata[wcg_pkg::LWRT_EN_BIT];
          cfg_r.lwrt_on <= pwdata[wcg_pkg::LWRT_ON_BIT];
          cfg_r.gate_force <= pwdata[wcg_pkg::GATE_BIT];
          cfg_r.pat_sel[1:0] <= pwdata[wcg_pkg::PAT_LO_LSB +: 2];
        end
        wcg_pkg::IDX_MOD_CTRL_B: begin
          cfg_r.override <= pwdata[wcg_pkg::OVR_BIT];
          cfg_r.forced_on <= pwdata[wcg_pkg::FORCED_BIT];
          cfg_r.pat_sel[2] <= pwdata[wcg_pkg::PAT_HI_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; reserved and upper bits read as zero
  always_comb begin
    rd_nxt = 8'h00;
    case (reg_idx[7:0])
      wcg_pkg::IDX_CLK_CTRL_A: rd_nxt = {cfg_r.bw, cfg_r.bypass, cfg_r.div,
        1'b0};
      wcg_pkg::IDX_CLK_CTRL_B: rd_nxt = {cfg_r.ref_src, cfg_r.pos_src,
        cfg_r.mult};
      wcg_pkg::IDX_MOD_CTRL_A: rd_nxt = {2'h0, cfg_r.lwrt_en, cfg_r.lwrt_on,
        cfg_r.gate_force, cfg_r.pat_sel[1:0], 1'b0};
      wcg_pkg::IDX_MOD_CTRL_B: rd_nxt = {5'h00, cfg_r.override,
        cfg_r.forced_on, cfg_r.pat_sel[2]};
      wcg_pkg::IDX_STATUS: rd_nxt = {4'h0, pat_level_r, laser_enable_out,
        write_clock_double_out, clock_run};
      default: rd_nxt = 8'h00;
    endcase
  end

  // read data captured in the setup phase so it stands for the access
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= (idx_ok && !pwrite) ? {24'h000000, rd_nxt} : 32'h00000000;
    end
  end

  // ==========================================================
  // reference pins: two flops, then an edge detect on the second
  for (genvar g = 0; g < 2; g++) begin : g_pin
    always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
        pin_sync1_r[g] <= 1'b0;
        pin_sync2_r[g] <= 1'b0;
        pin_prev_r[g] <= 1'b0;
      end else begin
        pin_sync1_r[g] <= g == 0 ? wobble_carrier_pulse_in : word_clock_in;
        pin_sync2_r[g] <= pin_sync1_r[g];
        pin_prev_r[g] <= pin_sync2_r[g];
      end
    end
    assign pin_tick[g] = pin_sync2_r[g] && !pin_prev_r[g];
  end

  // system clock over 192 as the third reference
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sysdiv_cnt_r <= 8'h00;
    end else begin
      sysdiv_cnt_r <= sysdiv_tick ? 8'h00 : sysdiv_cnt_r + 8'h01;
    end
  end
  assign sysdiv_tick = sysdiv_cnt_r == wcg_pkg::SYSDIV_LAST;

  // reference multiplexer; reserved code gives no reference at all
  always_comb begin
    case (cfg_r.ref_src)
      wcg_pkg::REF_WOBBLE: ref_tick = pin_tick[0];
      wcg_pkg::REF_WORD: ref_tick = pin_tick[1];
      wcg_pkg::REF_SYSDIV: ref_tick = sysdiv_tick;
      default: ref_tick = 1'b0;
    endcase
  end

  // position error source
  always_comb begin
    case (cfg_r.pos_src)
      wcg_pkg::POS_NONE: pos_err = 7'sh00;
      wcg_pkg::POS_PHASE: pos_err = phase_position_error_in;
      wcg_pkg::POS_FILL: pos_err = buffer_fill_level_in;
      default: pos_err = 7'sh00;
    endcase
  end

  wcg_dpll u_dpll (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .ref_tick_in(ref_tick),
    .mult_q_in(wcg_pkg::wcg_mult_q(cfg_r.mult)),
    .bw_shift_in(wcg_pkg::wcg_bw_shift(cfg_r.bw)),
    .pos_err_in(pos_err),
    .pll_tick_out(pll_tick)
  );

  // bypass substitutes the system clock for the loop output
  assign src_tick = cfg_r.bypass ? 1'b1 : pll_tick;

  wcg_divider u_div (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .src_tick_in(src_tick),
    .div_code_in(cfg_r.div),
    .clk_out(div_clk),
    .clk_double_out(div_dbl),
    .bit_tick_out(bit_tick)
  );

  // ==========================================================
  // gating: override wins over the normal gate and the data flow flag
  assign clock_run = cfg_r.override ? cfg_r.forced_on
    : (cfg_r.gate_force || data_flow_flag_in);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      write_clock_out <= 1'b0;
      write_clock_double_out <= 1'b0;
      laser_enable_out <= 1'b0;
    end else begin
      write_clock_out <= div_clk && clock_run;
      write_clock_double_out <= div_dbl && clock_run;
      laser_enable_out <= cfg_r.lwrt_on
        || (cfg_r.lwrt_en && write_active_flag_in);
    end
  end

  // ==========================================================
  // test patterns advance one bit per write clock period
  always_comb begin
    case (cfg_r.pat_sel)
      wcg_pkg::PAT_SHORT: run_len = wcg_pkg::SHORT_RUN;
      wcg_pkg::PAT_LONG: run_len = wcg_pkg::LONG_RUN;
      wcg_pkg::PAT_OPC: run_len = wcg_pkg::OPC_BASE_RUN
        + {1'b0, opc_idx_r[3:1]};
      default: run_len = wcg_pkg::SHORT_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      run_cnt_r <= 4'h0;
      opc_idx_r <= 4'h0;
      pat_level_r <= 1'b0;
    end else if (cfg_r.pat_sel != wcg_pkg::PAT_OPC
        && opc_idx_r != 4'h0 && bit_tick) begin
      opc_idx_r <= 4'h0;
      run_cnt_r <= 4'h0;
    end else if (bit_tick) begin
      if (run_cnt_r >= run_len - 4'h1) begin
        run_cnt_r <= 4'h0;
        pat_level_r <= ~pat_level_r;
        if (cfg_r.pat_sel == wcg_pkg::PAT_OPC) begin
          opc_idx_r <= opc_idx_r == wcg_pkg::OPC_LAST_IDX ? 4'h0
            : opc_idx_r + 4'h1;
        end
      end else begin
        run_cnt_r <= run_cnt_r + 4'h1;
      end
    end
  end

  // reserved codes hold the output low
  always_comb begin
    case (cfg_r.pat_sel)
      wcg_pkg::PAT_ZERO: data_nxt = 1'b0;
      wcg_pkg::PAT_NORMAL: data_nxt = modulated_data_in;
      wcg_pkg::PAT_SHORT: data_nxt = pat_level_r;
      wcg_pkg::PAT_LONG: data_nxt = pat_level_r;
      wcg_pkg::PAT_OPC: data_nxt = pat_level_r;
      default: data_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      write_data_out <= 1'b0;
    end else begin
      write_data_out <= data_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_override_off: assert property (
    (cfg_r.override && !cfg_r.forced_on) |=> !write_clock_out)
    else $error("write clock ran while forced off");
  a_override_runs: assert property (
    (cfg_r.override && cfg_r.forced_on && div_clk) |=> write_clock_out)
    else $error("write clock gated while forced on");
  a_gate_idle: assert property (
    (!cfg_r.override && !cfg_r.gate_force && !data_flow_flag_in)
    |=> !write_clock_out)
    else $error("write clock ran without data flow");
  a_gate_force: assert property (
    (!cfg_r.override && cfg_r.gate_force && div_clk) |=> write_clock_out)
    else $error("forced gate did not pass the clock");
  a_zero_pattern: assert property (
    cfg_r.pat_sel == 3'h0 |=> !write_data_out)
    else $error("zero pattern not held low");
  a_normal_data: assert property (
    cfg_r.pat_sel == 3'h1 |=> write_data_out == $past(modulated_data_in))
    else $error("normal data not passed");
  a_opc_run_end: assert property (
    (cfg_r.pat_sel == 3'h5 && bit_tick && run_cnt_r == run_len - 4'h1)
    |=> pat_level_r != $past(pat_level_r))
    else $error("calibration run did not end");
  a_sysdiv_period: assert property (
    sysdiv_tick |-> ##192 sysdiv_tick)
    else $error("reference divider period wrong");
  a_mod_b_store: assert property (
    (wr_en && reg_idx == (ADDR_W-2)'(wcg_pkg::IDX_MOD_CTRL_B))
    |=> cfg_r.pat_sel[2] == $past(pwdata[0]))
    else $error("pattern top bit not stored");
  a_bypass_tick: assert property (
    (cfg_r.bypass && cfg_r.div == wcg_pkg::DIV_ONE)
    |=> div_clk != $past(div_clk))
    else $error("bypass did not use the system clock");

  c_opc_toggle: cover property (cfg_r.pat_sel == 3'h5 && bit_tick);
  c_forced_on: cover property (cfg_r.override && write_clock_out);
  c_double_run: cover property (write_clock_double_out);
  c_bypass_clk: cover property (cfg_r.bypass && write_clock_out);

endmodule

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the write clock output control
// Assumes: zero wait apb, byte address = 4 * index
// Notes:   bypass path keeps counts exact; no random stimulus
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic flow = 1'b0, mdat = 1'b0, wob = 1'b0, wclk = 1'b0, clr = 1'b1;
  logic act = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, wck, wck2, wdat, las;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, c1, c2, i, k;
  // ==========================================================
  // clock, reference pins and hang guard
  always #(wcg_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    wob <= (cyc % 50) < 25;
    wclk <= (cyc % 38) < 19;
    if (cyc > 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  wcg_write_clock_ctrl uut (.ref_clk_in(clk), .sys_rst_in(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wobble_carrier_pulse_in(wob),
    .word_clock_in(wclk), .data_flow_flag_in(flow),
    .write_active_flag_in(act), .modulated_data_in(mdat),
    .phase_position_error_in(7'h05), .buffer_fill_level_in(7'h10),
    .write_clock_out(wck), .write_clock_double_out(wck2),
    .write_data_out(wdat), .laser_enable_out(las));
  wcg_chan_model ch (.ref_clk_in(clk), .clear_in(clr),
    .write_clock_in(wck), .write_data_in(wdat));
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] a, m, b);
    apb(1'b1, wcg_pkg::IDX_CLK_CTRL_A, a);
    apb(1'b1, wcg_pkg::IDX_MOD_CTRL_A, m);
    apb(1'b1, wcg_pkg::IDX_MOD_CTRL_B, b);
    clr <= 1'b1;
    repeat (4) @(posedge clk);
    clr <= 1'b0;
  endtask
  // count level changes of both write clocks over 32 cycles
  task automatic edges();
    logic p1, p2;
    c1 = 0;
    c2 = 0;
    @(posedge clk);
    p1 = wck;
    p2 = wck2;
    repeat (32) begin
      @(posedge clk);
      c1 += (wck !== p1);
      c2 += (wck2 !== p2);
      p1 = wck;
      p2 = wck2;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, wcg_pkg::IDX_CLK_CTRL_A, 8'hFF);
    apb(1'b0, wcg_pkg::IDX_CLK_CTRL_A, 8'h00);
    chk(rd, 32'h000000FE);
    apb(1'b1, wcg_pkg::IDX_MOD_CTRL_B, 8'hFF);
    apb(1'b0, wcg_pkg::IDX_MOD_CTRL_B, 8'h00);
    chk(rd, 32'h00000007);
    // laser follows the write flag; the forced clock must not care
    apb(1'b1, wcg_pkg::IDX_MOD_CTRL_A, 8'h20);
    apb(1'b0, wcg_pkg::IDX_STATUS, 8'h00);
    chk(rd & 32'h5, 32'h1);
    act <= 1'b1;
    apb(1'b0, wcg_pkg::IDX_STATUS, 8'h00);
    chk({las, rd[30:0] & 31'h5}, 32'h80000005);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, wcg_pkg::IDX_CLK_CTRL_B, {i[1:0], 6'h2A});
      apb(1'b0, wcg_pkg::IDX_CLK_CTRL_B, 8'h00);
      chk(rd, {24'h000000, i[1:0], 6'h2A});
    end
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h1);
    cfg(8'h10, 8'h08, 8'h00);
    edges();
    chk(c1, 32);
    chk(c2, 0);
    chk({31'h0, wdat}, 32'h0);
    cfg(8'h12, 8'h08, 8'h00);
    edges();
    chk(c1, 16);
    chk(c2, 32);
    cfg(8'h10, 8'h00, 8'h02);
    edges();
    chk(c1, 0);
    flow <= 1'b1;
    // let the gate open before the first sample, else one change is lost
    @(posedge clk);
    edges();
    chk(c1, 32);
    cfg(8'h10, 8'h08, 8'h04);
    edges();
    chk(c1, 0);
    flow <= 1'b0;
    cfg(8'h10, 8'h00, 8'h06);
    edges();
    chk(c1, 32);
    cfg(8'h10, 8'h0A, 8'h00);
    mdat <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, wdat}, 32'h1);
    // short and long runs: three then eleven bit times per run
    for (i = 2; i < 4; i++) begin
      cfg(8'h10, {5'h01, i[1:0], 1'b0}, 8'h00);
      repeat (300) @(posedge clk);
      for (k = 1; k < 5; k++) chk(ch.runs[k], i == 2 ? 3 : 11);
    end
    cfg(8'h10, 8'h0A, 8'h01);
    repeat (300) @(posedge clk);
    k = 1;
    for (i = 10; i > 0; i--) begin
      if (ch.runs[i] == 3 && ch.runs[i + 1] == 3 && ch.runs[i + 2] == 4) begin
        k = i;
      end
    end
    for (i = 0; i < 10; i++) chk(ch.runs[k + i], 3 + i / 2);
    end_of_test();
  end
endmodule

// ==== verification/wcg_chan_model.sv ====
// Purpose: write channel model, logs data run lengths
// Assumes: one data bit taken at each write clock rise
// Notes:   keeps the first 32 runs after a clear
`timescale 1ns/100ps
module wcg_chan_model (
  // system side
  input wire logic ref_clk_in,
  input wire logic clear_in,
  // write channel
  input wire logic write_clock_in,
  input wire logic write_data_in
);
  logic [7:0] runs [0:31];
  logic [5:0] n_runs;
  logic [7:0] len;
  logic clk_q;
  logic dat_q;
  // a level change closes a run; the first run may be partial
  always @(posedge ref_clk_in) begin
    clk_q <= write_clock_in;
    if (clear_in) begin
      n_runs <= 6'h00;
      len <= 8'h00;
    end else if (write_clock_in && !clk_q) begin
      dat_q <= write_data_in;
      if (write_data_in !== dat_q && len != 8'h00) begin
        if (n_runs < 6'h20) runs[n_runs[4:0]] <= len;
        n_runs <= n_runs + 6'h01;
        len <= 8'h01;
      end else len <= len + 8'h01;
    end
  end
endmodule
